// ---- rtl/pcmi_defs.vh ----
// Constants for the printer command interface block
`ifndef PCMI_DEFS_VH
`define PCMI_DEFS_VH

// Timing
`define PCMI_CLK_NS 100
`define PCMI_STROBE_MIN_NS 1000
`define PCMI_STROBE_CYCLES ((`PCMI_STROBE_MIN_NS + `PCMI_CLK_NS - 1) / `PCMI_CLK_NS)
`define PCMI_SETTLE_MS 100
`define PCMI_SETTLE_CYCLES ((`PCMI_SETTLE_MS * 1000000) / `PCMI_CLK_NS)

// Strobe line indices
`define PCMI_FN_PW 0
`define PCMI_FN_CAR 1
`define PCMI_FN_PF 2
`define PCMI_FN_OPT 3

// Function address codes sent to the data file
`define PCMI_ADDR_PF 2'h0
`define PCMI_ADDR_OPT 2'h1
`define PCMI_ADDR_CAR 2'h2
`define PCMI_ADDR_PW 2'h3

// Register byte offsets
`define PCMI_REG_STATUS 8'h00
`define PCMI_REG_CONTROL 8'h04
`define PCMI_REG_DATA_LO 8'h08
`define PCMI_REG_DATA_HI 8'h0C
`define PCMI_REG_OPTION 8'h10
`define PCMI_REG_INT_STATUS 8'h14
`define PCMI_REG_INT_MASK 8'h18

// Status fields
`define PCMI_ST_SELECTED 0
`define PCMI_ST_RESTORE 1
`define PCMI_ST_CHECK 2
`define PCMI_ST_BUSY_LSB 3
`define PCMI_ST_SETTLE 7
`define PCMI_ST_PBH 8
`define PCMI_ST_PBV 9
`define PCMI_ST_RIBBON_UP 10
`define PCMI_ST_ADDR_LSB 12
`define PCMI_ST_LATCHED 14

// Control fields, write one to act
`define PCMI_CTL_RELEASE 0
`define PCMI_CTL_RESTORE_START 1
`define PCMI_CTL_RESTORE_DONE 2
`define PCMI_CTL_CHECK_SET 3

// Interrupt fields
`define PCMI_INT_W 3
`define PCMI_INT_ACCEPT 0
`define PCMI_INT_HOST_RESTORE 1
`define PCMI_INT_RIBBON 2
`define PCMI_INT_MASK_RESET 3'h0

`endif

// ---- rtl/pcmi_sync.v ----
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module pcmi_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire clock_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge clock_i) begin
        if (rst_i) begin
            stage1 <= INIT;
            stage2 <= INIT;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;
endmodule // pcmi_sync
`default_nettype wire

// ---- rtl/pcmi_filter.v ----
// Per-line minimum-width pulse filter for the activity strobes
`timescale 1ns/1ps
`default_nettype none
module pcmi_filter #(
    parameter LINES = 4,
    parameter CYCLES = 10,
    parameter CW = 8
) (
    input wire clock_i,
    input wire rst_i,
    input wire [LINES-1:0] level_i,
    output wire [LINES-1:0] pulse_o
);
    localparam integer LAST_I = CYCLES - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1) begin : g_line
            reg [CW-1:0] count;
            reg fired;
            always @(posedge clock_i) begin
                if (rst_i || !level_i[g]) begin
                    count <= {CW{1'b0}};
                    fired <= 1'b0;
                end else if (count != LAST) begin
                    count <= count + 1'b1;
                end else begin
                    fired <= 1'b1;
                end
            end
            // One pulse per strobe, once it has lasted long enough
            assign pulse_o[g] = level_i[g] && (count == LAST) && !fired;
        end
    endgenerate
endmodule // pcmi_filter
`default_nettype wire

// ---- rtl/pcmi_top.v ----
// Printer command interface: host strobes, ready/check status and APB access for the microprocessor
// Summary of operation
// - Commands other than host restore are ignored until select is low; then status outputs and strobes work.
// - Accepted strobe sets a latch that refuses further strobes until cleared.
// - Accepted strobe drives its own ready output high as busy.
// - Fired strobe line picks the data file address where data is stored.
// - Microprocessor release clears the latch and returns the ready line low.
// - Restore starts after power-up, on host restore command or on a microprocessor restore-start control write.
// - During restore strobes are disabled and all ready lines high.
// - Restore clears the strobe latch, check, print-before, ribbon and settle flip-flops and holds the data address at print wheel.
// - Check drives ready lines high, blocks strobes and asserts check status.
// - Check is left only through a restore sequence.
// - Ribbon lift or lower passes position on and holds print-wheel ready high.
// - Twelve-bit command word is read as a low 8-bit part and a high 4-bit part.
// - Reads also return data address, print-before ordering and option commands.
// - Print-wheel ready stays high about 100 ms after ribbon command.
// - Strobe pulses shorter than 1 us are ignored by a clocked filter.
// - Four strobes, print wheel, carriage, paper feed, option, each with ready.
`timescale 1ns/1ps
`default_nettype none
`include "pcmi_defs.vh"
module pcmi_top #(
    parameter DATA_W = 12,
    parameter SETTLE_CYCLES = `PCMI_SETTLE_CYCLES
) (
    input wire clock_i,
    input wire rst_i,
    input wire select_n_i,
    input wire [DATA_W-1:0] data_n_i,
    input wire [3:0] strobe_n_i,
    input wire restore_n_i,
    input wire ribbon_lift_n_i,
    input wire ribbon_lower_n_i,
    output reg [3:0] ready_n_o,
    output reg check_n_o,
    output reg restore_o,
    output reg ribbon_up_o,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    output reg irq_o
);
    localparam SW = $clog2(SETTLE_CYCLES + 1);
    localparam integer SETTLE_I = SETTLE_CYCLES;
    localparam [SW-1:0] SETTLE_LOAD = SETTLE_I[SW-1:0];
    localparam SYNC_W = DATA_W + 8;
    localparam FILT_CW = $clog2(`PCMI_STROBE_CYCLES + 1);

    // Pin synchronisation
    wire [SYNC_W-1:0] pins_sync;
    wire selected;
    wire host_restore_lvl;
    wire lift_lvl;
    wire lower_lvl;
    wire [3:0] strobe_lvl;
    wire [DATA_W-1:0] data_true;

    pcmi_sync #(
        .WIDTH(SYNC_W),
        .INIT({SYNC_W{1'b1}})
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({ribbon_lower_n_i, ribbon_lift_n_i, restore_n_i, select_n_i, strobe_n_i, data_n_i}),
        .sync_o(pins_sync)
    );

    assign data_true = ~pins_sync[DATA_W-1:0];
    assign strobe_lvl = ~pins_sync[DATA_W+3:DATA_W];
    assign selected = ~pins_sync[DATA_W+4];
    assign host_restore_lvl = ~pins_sync[DATA_W+5];
    assign lift_lvl = ~pins_sync[DATA_W+6];
    assign lower_lvl = ~pins_sync[DATA_W+7];

    wire [3:0] strobe_ok;
    pcmi_filter #(
        .LINES(4),
        .CYCLES(`PCMI_STROBE_CYCLES),
        .CW(FILT_CW)
    ) u_filter (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(strobe_lvl),
        .pulse_o(strobe_ok)
    );

    // Edge detect on already synchronised levels
    reg host_restore_d;
    reg lift_d;
    reg lower_d;
    wire host_restore_evt = host_restore_lvl && !host_restore_d;
    wire lift_evt = lift_lvl && !lift_d;
    wire lower_evt = lower_lvl && !lower_d;

    // Control state
    reg restore_st;
    reg check_st;
    reg [3:0] latch_vec;
    reg [1:0] func_addr;
    reg pbh;
    reg pbv;
    reg [SW-1:0] settle_cnt;
    reg [DATA_W-1:0] data_file [0:3];
    reg [`PCMI_INT_W-1:0] int_status;
    reg [`PCMI_INT_W-1:0] int_mask;

    wire latched = |latch_vec;
    wire settling = (settle_cnt != {SW{1'b0}});

    // APB decode
    wire apb_setup = psel_i && !penable_i;
    wire apb_write = psel_i && penable_i && pwrite_i;
    reg addr_hit;
    always @* begin
        case (paddr_i)
            `PCMI_REG_STATUS,
            `PCMI_REG_CONTROL,
            `PCMI_REG_DATA_LO,
            `PCMI_REG_DATA_HI,
            `PCMI_REG_OPTION,
            `PCMI_REG_INT_STATUS,
            `PCMI_REG_INT_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Zero wait states; unmapped access answers with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

    wire ctl_wr = apb_write && (paddr_i == `PCMI_REG_CONTROL);
    wire release_cmd = ctl_wr && pwdata_i[`PCMI_CTL_RELEASE];
    wire restore_start_cmd = ctl_wr && pwdata_i[`PCMI_CTL_RESTORE_START];
    wire restore_done_cmd = ctl_wr && pwdata_i[`PCMI_CTL_RESTORE_DONE];
    wire check_set_cmd = ctl_wr && pwdata_i[`PCMI_CTL_CHECK_SET];

    wire strobe_enable = selected && !restore_st && !check_st && !latched;

    // Lowest line wins if two strobes mature together
    reg [3:0] pick;
    reg [1:0] pick_addr;
    always @* begin
        pick = 4'h0;
        pick_addr = `PCMI_ADDR_PW;
        if (strobe_ok[`PCMI_FN_PW]) begin
            pick[`PCMI_FN_PW] = 1'b1;
            pick_addr = `PCMI_ADDR_PW;
        end else if (strobe_ok[`PCMI_FN_CAR]) begin
            pick[`PCMI_FN_CAR] = 1'b1;
            pick_addr = `PCMI_ADDR_CAR;
        end else if (strobe_ok[`PCMI_FN_PF]) begin
            pick[`PCMI_FN_PF] = 1'b1;
            pick_addr = `PCMI_ADDR_PF;
        end else if (strobe_ok[`PCMI_FN_OPT]) begin
            pick[`PCMI_FN_OPT] = 1'b1;
            pick_addr = `PCMI_ADDR_OPT;
        end
    end

    wire accept = strobe_enable && (|strobe_ok);
    wire ribbon_evt = selected && !restore_st && (lift_evt || lower_evt);
    wire restore_req = host_restore_evt || restore_start_cmd;

    always @(posedge clock_i) begin
        if (rst_i) begin
            host_restore_d <= 1'b0;
            lift_d <= 1'b0;
            lower_d <= 1'b0;
        end else begin
            host_restore_d <= host_restore_lvl;
            lift_d <= lift_lvl;
            lower_d <= lower_lvl;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            // Power-up enters restore
            restore_st <= 1'b1;
            check_st <= 1'b0;
        end else begin
            // Restart wins over completion
            if (restore_req)
                restore_st <= 1'b1;
            else if (restore_done_cmd)
                restore_st <= 1'b0;
            if (restore_st || restore_req)
                check_st <= 1'b0;
            else if (check_set_cmd)
                check_st <= 1'b1;
        end
    end

    // Strobe latch, data address and cycle data latches
    always @(posedge clock_i) begin
        if (rst_i || restore_st) begin
            latch_vec <= 4'h0;
            func_addr <= `PCMI_ADDR_PW;
            pbh <= 1'b0;
            pbv <= 1'b0;
        end else if (accept) begin
            latch_vec <= pick;
            func_addr <= pick_addr;
            // Print-before order follows a pending print-wheel command
            if (pick[`PCMI_FN_CAR])
                pbh <= latch_vec[`PCMI_FN_PW];
            if (pick[`PCMI_FN_PF] || pick[`PCMI_FN_OPT])
                pbv <= latch_vec[`PCMI_FN_PW];
        end else if (release_cmd) begin
            latch_vec <= 4'h0;
        end
    end

    integer i;
    always @(posedge clock_i) begin
        if (rst_i) begin
            for (i = 0; i < 4; i = i + 1)
                data_file[i] <= {DATA_W{1'b0}};
        end else if (accept) begin
            data_file[pick_addr] <= data_true;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i || restore_st) begin
            ribbon_up_o <= 1'b0;
            settle_cnt <= {SW{1'b0}};
        end else if (ribbon_evt) begin
            // Lift wins if both arrive together
            ribbon_up_o <= lift_evt;
            settle_cnt <= SETTLE_LOAD;
        end else if (settling) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
    end

    // Host status lines
    reg [3:0] next_ready_n;
    always @* begin
        if (!selected) begin
            next_ready_n = 4'hF;
        end else if (restore_st || check_st) begin
            next_ready_n = 4'hF;
        end else begin
            next_ready_n = latch_vec;
            if (settling)
                next_ready_n[`PCMI_FN_PW] = 1'b1;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            ready_n_o <= 4'hF;
            check_n_o <= 1'b1;
            restore_o <= 1'b1;
        end else begin
            ready_n_o <= next_ready_n;
            check_n_o <= !(selected && check_st);
            restore_o <= restore_st;
        end
    end

    // Interrupts: set wins over write-one clear
    wire [`PCMI_INT_W-1:0] int_events;
    assign int_events[`PCMI_INT_ACCEPT] = accept;
    assign int_events[`PCMI_INT_HOST_RESTORE] = host_restore_evt;
    assign int_events[`PCMI_INT_RIBBON] = ribbon_evt;
    wire int_clr_wr = apb_write && (paddr_i == `PCMI_REG_INT_STATUS);
    wire int_mask_wr = apb_write && (paddr_i == `PCMI_REG_INT_MASK);

    always @(posedge clock_i) begin
        if (rst_i) begin
            int_status <= {`PCMI_INT_W{1'b0}};
            int_mask <= `PCMI_INT_MASK_RESET;
            irq_o <= 1'b0;
        end else begin
            if (int_clr_wr)
                int_status <= (int_status & ~pwdata_i[`PCMI_INT_W-1:0]) | int_events;
            else
                int_status <= int_status | int_events;
            if (int_mask_wr)
                int_mask <= pwdata_i[`PCMI_INT_W-1:0];
            irq_o <= |(int_status & int_mask);
        end
    end

    // Status word
    wire [31:0] status_word;
    assign status_word[`PCMI_ST_SELECTED] = selected;
    assign status_word[`PCMI_ST_RESTORE] = restore_st;
    assign status_word[`PCMI_ST_CHECK] = check_st;
    assign status_word[`PCMI_ST_BUSY_LSB+3:`PCMI_ST_BUSY_LSB] = latch_vec;
    assign status_word[`PCMI_ST_SETTLE] = settling;
    assign status_word[`PCMI_ST_PBH] = pbh;
    assign status_word[`PCMI_ST_PBV] = pbv;
    assign status_word[`PCMI_ST_RIBBON_UP] = ribbon_up_o;
    assign status_word[11] = 1'b0;
    assign status_word[`PCMI_ST_ADDR_LSB+1:`PCMI_ST_ADDR_LSB] = func_addr;
    assign status_word[`PCMI_ST_LATCHED] = latched;
    assign status_word[31:15] = 17'h00000;

    // command word in two parts, low byte and high 4 bits
    wire [DATA_W-1:0] cur_word = data_file[func_addr];
    wire [DATA_W-1:0] opt_word = data_file[`PCMI_ADDR_OPT];
    wire [31:0] data_lo_word = {24'h000000, cur_word[7:0]};
    wire [31:0] data_hi_word = {{(40-DATA_W){1'b0}}, cur_word[DATA_W-1:8]};
    wire [31:0] option_word = {{(32-DATA_W){1'b0}}, opt_word};

    // Read data captured in setup so it stands from a flip-flop in access
    reg [31:0] next_prdata;
    always @* begin
        case (paddr_i)
            `PCMI_REG_STATUS: next_prdata = status_word;
            `PCMI_REG_DATA_LO: next_prdata = data_lo_word;
            `PCMI_REG_DATA_HI: next_prdata = data_hi_word;
            `PCMI_REG_OPTION: next_prdata = option_word;
            `PCMI_REG_INT_STATUS: next_prdata = {{(32-`PCMI_INT_W){1'b0}}, int_status};
            `PCMI_REG_INT_MASK: next_prdata = {{(32-`PCMI_INT_W){1'b0}}, int_mask};
            default: next_prdata = 32'h00000000;
        endcase
    end

    always @(posedge clock_i) begin
        if (rst_i)
            prdata_o <= 32'h00000000;
        else if (apb_setup)
            prdata_o <= next_prdata;
    end
endmodule // pcmi_top
`default_nettype wire

// ---- tb/pcmi_checker.sv ----
// Port-level assertions for the printer command interface
`timescale 1ns/1ps
`default_nettype none
`include "pcmi_defs.vh"
module pcmi_checker (
    input wire clock_i,
    input wire rst_i,
    input wire select_n_i,
    input wire [3:0] strobe_n_i,
    input wire ribbon_lift_n_i,
    input wire [3:0] ready_n_o,
    input wire check_n_o,
    input wire restore_o,
    input wire ribbon_up_o,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pslverr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [3:0] sel_hist;
    logic sel_ok;
    logic ctl_wr;
    // Select must have been low long enough to pass the synchroniser
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sel_hist <= 4'hF;
        end else begin
            sel_hist <= {sel_hist[2:0], select_n_i};
        end
    end
    assign sel_ok = (sel_hist == 4'h0);
    assign ctl_wr = psel_i && penable_i && pwrite_i && (paddr_i == `PCMI_REG_CONTROL);
    a_unsel_quiet: assert property (select_n_i [*5] |-> ready_n_o == 4'hF && check_n_o)
        else $error("status not held while unselected");
    a_accept_cause: assert property ((($rose(ready_n_o[1]) && sel_ok) ##1 (check_n_o && !restore_o))
        |-> $past(strobe_n_i[1], 5) == 1'b0)
        else $error("carriage busy without a strobe");
    a_release_ready: assert property ((ctl_wr && pwdata_i[0] && pwdata_i[3:1] == 3'h0 && sel_ok && !restore_o
        && check_n_o) |-> ##2 ready_n_o[3:1] == 3'h0)
        else $error("ready not returned after release");
    a_restore_busy: assert property (restore_o && $past(restore_o) |-> ready_n_o == 4'hF)
        else $error("ready low during restore");
    a_check_busy: assert property (!check_n_o && !$past(check_n_o) |-> ready_n_o == 4'hF)
        else $error("ready low during check");
    a_check_exit: assert property ($rose(check_n_o) && sel_ok |-> restore_o || $past(restore_o))
        else $error("check left without restore");
    a_ribbon_pos: assert property ($fell(ribbon_lift_n_i) && sel_ok && !restore_o |-> ##[1:6] ribbon_up_o)
        else $error("ribbon lift not passed on");
    a_hi_part: assert property (psel_i && penable_i && !pwrite_i && paddr_i == `PCMI_REG_DATA_HI
        |-> prdata_o[31:4] == 28'h0)
        else $error("upper command part too wide");
    a_unmapped_err: assert property (psel_i && penable_i
        |-> pslverr_o == (paddr_i > `PCMI_REG_INT_MASK || paddr_i[1:0] != 2'h0))
        else $error("slave error on wrong address");
    c_accept: cover property ($rose(ready_n_o[1]));
    c_check: cover property ($fell(check_n_o));
    c_ribbon: cover property ($rose(ribbon_up_o));
endmodule // pcmi_checker
bind pcmi_top pcmi_checker u_pcmi_checker (.clock_i, .rst_i, .select_n_i, .strobe_n_i, .ribbon_lift_n_i,
    .ready_n_o, .check_n_o, .restore_o, .ribbon_up_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pslverr_o);
`default_nettype wire

// ---- tb/pcmi_host.sv ----
// Host controller model: select, command data, strobes and command pins
`timescale 1ns/1ps
`default_nettype none
module pcmi_host (
    input wire logic clock_i,
    output logic select_n_o,
    output logic [11:0] data_n_o,
    output logic [3:0] strobe_n_o,
    output logic [2:0] cmd_n_o
);
    initial begin
        select_n_o = 1'b1;
        data_n_o = 12'hFFF;
        strobe_n_o = 4'hF;
        cmd_n_o = 3'h7;
    end
    task automatic select(input logic on);
        @(posedge clock_i);
        select_n_o <= ~on;
    endtask
    task automatic send(input logic [1:0] fn, input logic [11:0] val, input int hold);
        @(posedge clock_i);
        data_n_o <= ~val;
        repeat (2) @(posedge clock_i);
        strobe_n_o[fn] <= 1'b0;
        repeat (hold) @(posedge clock_i);
        strobe_n_o[fn] <= 1'b1;
        // Released lines show the inverse, not a kind held copy
        data_n_o <= val;
    endtask
    // Bit 0 restore, 1 lift, 2 lower
    task automatic pulse(input int b);
        @(posedge clock_i);
        cmd_n_o[b] <= 1'b0;
        repeat (3) @(posedge clock_i);
        cmd_n_o[b] <= 1'b1;
    endtask
endmodule // pcmi_host
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the printer command interface
`timescale 1ns/1ps
`default_nettype none
`include "pcmi_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("Error at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
    localparam int SETTLE = 20;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    wire logic select_n_i, restore_n_i, ribbon_lift_n_i, ribbon_lower_n_i, check_n_o, restore_o, ribbon_up_o;
    wire logic pready_o, pslverr_o, irq_o;
    wire logic [11:0] data_n_i;
    wire logic [3:0] strobe_n_i, ready_n_o;
    wire logic [31:0] prdata_o;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic last_err;
    always #50 clock_i = ~clock_i;
    pcmi_top #(.DATA_W(12), .SETTLE_CYCLES(SETTLE)) u_pcmi_top (.clock_i, .rst_i, .select_n_i, .data_n_i,
        .strobe_n_i, .restore_n_i, .ribbon_lift_n_i, .ribbon_lower_n_i, .ready_n_o, .check_n_o, .restore_o,
        .ribbon_up_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .irq_o);
    pcmi_host u_pcmi_host (.clock_i, .select_n_o(select_n_i), .data_n_o(data_n_i), .strobe_n_o(strobe_n_i),
        .cmd_n_o({ribbon_lower_n_i, ribbon_lift_n_i, restore_n_i}));
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 20) begin
            fail_count++;
            end_sim;
        end
        rd = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task wait_ready(input int k, input logic v);
        int n;
        n = 0;
        while (ready_n_o[k] !== v && n < 40) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 40) begin
            fail_count++;
            end_sim;
        end
    endtask
    task t_reset;
        `CHK(restore_o, 1'b1)
        apb(`PCMI_REG_INT_MASK, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        apb(`PCMI_REG_CONTROL, 1'b1, 32'h4);
        u_pcmi_host.send(2'd1, 12'h123, 12);
        repeat (6) @(posedge clock_i);
        `CHK(ready_n_o, 4'hF)
        apb(`PCMI_REG_STATUS, 1'b0, 32'h0);
        `CHK(rd[`PCMI_ST_LATCHED], 1'b0)
    endtask
    task t_accept;
        logic [11:0] val;
        logic [1:0] ad;
        u_pcmi_host.select(1'b1);
        apb(`PCMI_REG_INT_MASK, 1'b1, 32'h7);
        // Ready is registered behind the select synchroniser
        @(posedge clock_i);
        `CHK(ready_n_o, 4'h0)
        for (int fn = 0; fn < 4; fn++) begin
            val = 12'hA50 | 12'(fn);
            ad = (fn == 0) ? `PCMI_ADDR_PW : (fn == 1) ? `PCMI_ADDR_CAR : (fn == 2) ? `PCMI_ADDR_PF : `PCMI_ADDR_OPT;
            u_pcmi_host.send(fn[1:0], val, 12);
            wait_ready(fn, 1'b1);
            `CHK(ready_n_o, 4'(1 << fn))
            apb(`PCMI_REG_STATUS, 1'b0, 32'h0);
            `CHK(rd[`PCMI_ST_ADDR_LSB +: 2], ad)
            if (fn == 0) begin
                u_pcmi_host.send(2'd2, 12'h3C3, 12);
                repeat (4) @(posedge clock_i);
                `CHK(ready_n_o, 4'h1)
            end
            apb(`PCMI_REG_DATA_LO, 1'b0, 32'h0);
            `CHK(rd, {24'h0, val[7:0]})
            apb(`PCMI_REG_DATA_HI, 1'b0, 32'h0);
            `CHK(rd, {28'h0, val[11:8]})
            `CHK(irq_o, 1'b1)
            apb(`PCMI_REG_CONTROL, 1'b1, 32'h1);
            wait_ready(fn, 1'b0);
            `CHK(ready_n_o, 4'h0)
            apb(`PCMI_REG_INT_STATUS, 1'b1, 32'h1);
            repeat (2) @(posedge clock_i);
            `CHK(irq_o, 1'b0)
        end
        apb(`PCMI_REG_OPTION, 1'b0, 32'h0);
        `CHK(rd, 32'hA53)
    endtask
    task t_short;
        u_pcmi_host.send(2'd1, 12'h0FF, 5);
        repeat (20) @(posedge clock_i);
        `CHK(ready_n_o, 4'h0)
    endtask
    task t_check;
        apb(`PCMI_REG_CONTROL, 1'b1, 32'h8);
        repeat (2) @(posedge clock_i);
        `CHK(check_n_o, 1'b0)
        `CHK(ready_n_o, 4'hF)
        u_pcmi_host.send(2'd1, 12'h111, 12);
        repeat (4) @(posedge clock_i);
        apb(`PCMI_REG_STATUS, 1'b0, 32'h0);
        `CHK(rd[`PCMI_ST_LATCHED], 1'b0)
        u_pcmi_host.pulse(0);
        repeat (4) @(posedge clock_i);
        `CHK(restore_o, 1'b1)
        `CHK(check_n_o, 1'b1)
        apb(`PCMI_REG_INT_STATUS, 1'b0, 32'h0);
        `CHK(rd[`PCMI_INT_HOST_RESTORE], 1'b1)
        apb(`PCMI_REG_CONTROL, 1'b1, 32'h4);
        repeat (2) @(posedge clock_i);
        `CHK(restore_o, 1'b0)
        `CHK(ready_n_o, 4'h0)
        apb(`PCMI_REG_INT_STATUS, 1'b1, 32'h7);
        // Software-started restore
        apb(`PCMI_REG_CONTROL, 1'b1, 32'h2);
        repeat (2) @(posedge clock_i);
        `CHK(restore_o, 1'b1)
        `CHK(ready_n_o, 4'hF)
        apb(`PCMI_REG_CONTROL, 1'b1, 32'h4);
        repeat (2) @(posedge clock_i);
        `CHK(ready_n_o, 4'h0)
    endtask
    task t_ribbon;
        int n;
        for (int b = 1; b < 3; b++) begin
            n = 0;
            u_pcmi_host.pulse(b);
            wait_ready(0, 1'b1);
            `CHK(ribbon_up_o, b == 1)
            while (ready_n_o[0] === 1'b1 && n < 100) begin
                @(posedge clock_i);
                n++;
            end
            `CHK(n >= SETTLE - 2 && n <= SETTLE + 2, 1'b1)
        end
        apb(8'h40, 1'b0, 32'h0);
        `CHK(last_err, 1'b1)
        `CHK(rd, 32'h0)
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_reset;
        t_accept;
        t_short;
        t_check;
        t_ribbon;
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        fail_count++;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
